// [hw/ltr_capability_registers.sv]
// Summary of operation
// - header bits 15:0 read 0018h
// - header bits 19:16 read version 1h
// - header bits 31:20 read 000h
// - header at 230h, upstream port only
// - latency word at 234h, upstream only
// - snoop value bits 9:0, reset zero
// - snoop scale bits 12:10, reset zero
// - no-snoop value bits 25:16, reset zero
// - no-snoop scale bits 28:26, reset zero
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
module ltr_capability_registers (
  input wire logic I_CLOCK, // core clock, 25 MHz
  input wire logic I_RST_N, // async reset, active low
  input wire logic I_UPSTREAM, // high when port is upstream
  input wire logic [11:0] I_ADDR, // byte address
  input wire logic [31:0] I_WDATA, // write data
  input wire logic I_WR, // write strobe
  input wire logic I_RD, // read strobe
  output logic [31:0] O_RDATA, // read data, cycle after strobe
  output logic [9:0] O_SNOOP_VALUE, // max snoop latency value
  output logic [2:0] O_SNOOP_SCALE, // max snoop latency scale
  output logic [9:0] O_NOSNOOP_VALUE, // max no-snoop latency value
  output logic [2:0] O_NOSNOOP_SCALE // max no-snoop latency scale
);
  // ****************************************
  // decode
  // ****************************************
  logic [31:0] limit_word;
  logic [31:0] header_word;
  logic hit_header;
  logic hit_limit;
  logic limit_we;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic [9:0] snoop_value_q;
  logic [2:0] snoop_scale_q;
  logic [9:0] nosnoop_value_q;
  logic [2:0] nosnoop_scale_q;

  // ****************************************
  // helpers
  // ****************************************
  // address match, visible on the upstream port only
  function automatic logic reg_hit(input logic upstream, input logic [11:0] addr, input logic [11:0] offset);
    reg_hit = upstream && (addr == offset);
  endfunction

  // latency value field at a given position
  function automatic logic [ltr_cap_pkg::VAL_WIDTH-1:0] value_field(input logic [31:0] latency, input int lsb);
    value_field = latency[lsb +: ltr_cap_pkg::VAL_WIDTH];
  endfunction

  // latency scale field at a given position
  function automatic logic [ltr_cap_pkg::SCALE_WIDTH-1:0] scale_field(input logic [31:0] latency, input int lsb);
    scale_field = latency[lsb +: ltr_cap_pkg::SCALE_WIDTH];
  endfunction

  assign hit_header = reg_hit(I_UPSTREAM, I_ADDR, ltr_cap_pkg::HEADER_OFFSET);
  // latency word only on upstream port
  assign hit_limit = reg_hit(I_UPSTREAM, I_ADDR, ltr_cap_pkg::LIMIT_OFFSET);
  assign limit_we = I_WR && hit_limit;

  assign header_word = {ltr_cap_pkg::NEXT_OFFSET, ltr_cap_pkg::CAP_VERSION, ltr_cap_pkg::CAP_ID};

  // ****************************************
  // latency storage
  // ****************************************
  // stored latency word
  ltr_limit_store u_store (
    .i_clock(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_we(limit_we),
    .i_wdata(I_WDATA),
    .o_word(limit_word)
  );

  // read mux, zero when idle or unmapped
  assign rdata_d = !I_RD ? ltr_cap_pkg::READ_UNMAPPED :
                   hit_header ? header_word :
                   hit_limit ? limit_word : ltr_cap_pkg::READ_UNMAPPED;

  // ****************************************
  // output registers
  // ****************************************
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      snoop_value_q <= 10'h000;
      snoop_scale_q <= 3'h0;
      nosnoop_value_q <= 10'h000;
      nosnoop_scale_q <= 3'h0;
    end else if (limit_we) begin
      snoop_value_q <= value_field(I_WDATA, ltr_cap_pkg::SNOOP_VAL_LSB);
      snoop_scale_q <= scale_field(I_WDATA, ltr_cap_pkg::SNOOP_SCALE_LSB);
      nosnoop_value_q <= value_field(I_WDATA, ltr_cap_pkg::NOSNOOP_VAL_LSB);
      nosnoop_scale_q <= scale_field(I_WDATA, ltr_cap_pkg::NOSNOOP_SCALE_LSB);
    end
  end

  assign O_RDATA = rdata_q;
  assign O_SNOOP_VALUE = snoop_value_q;
  assign O_SNOOP_SCALE = snoop_scale_q;
  assign O_NOSNOOP_VALUE = nosnoop_value_q;
  assign O_NOSNOOP_SCALE = nosnoop_scale_q;

  // ****************************************
  // header checks
  // ****************************************
  // header id value
  chk_header_id_value: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_RD && hit_header) |=> O_RDATA[15:0] == 16'h0018)
    else $error("header id wrong");

  chk_header_version_value: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_RD && hit_header) |=> O_RDATA[19:16] == 4'h1)
    else $error("header version wrong");

  chk_header_next_zero: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_RD && hit_header) |=> O_RDATA[31:20] == 12'h000)
    else $error("next pointer not zero");

  chk_header_read_full: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_RD && hit_header) |=> O_RDATA == 32'h0001_0018)
    else $error("header word wrong");

  chk_header_write_ignored: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_WR && hit_header) |=> $stable(limit_word))
    else $error("header write changed latency word");

  chk_version_after_write: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    ((I_WR && hit_header) ##1 (I_RD && hit_header)) |=> O_RDATA[19:16] == 4'h1)
    else $error("version changed by write");

  chk_next_after_write: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    ((I_WR && hit_header) ##1 (I_RD && hit_header)) |=> O_RDATA[31:20] == 12'h000)
    else $error("next pointer changed by write");

  chk_downstream_reads_zero: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_RD && !I_UPSTREAM) |=> O_RDATA == 32'h0000_0000)
    else $error("downstream read not zero");

  chk_header_hidden_downstream: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_RD && !I_UPSTREAM && (I_ADDR == ltr_cap_pkg::HEADER_OFFSET)) |=> O_RDATA == 32'h0000_0000)
    else $error("header visible downstream");

  chk_downstream_write_ignored: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_WR && !I_UPSTREAM) |=> $stable(limit_word))
    else $error("downstream write stored");

  chk_downstream_fields_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_WR && !I_UPSTREAM) |=> $stable(O_SNOOP_VALUE) && $stable(O_SNOOP_SCALE) &&
    $stable(O_NOSNOOP_VALUE) && $stable(O_NOSNOOP_SCALE))
    else $error("downstream write moved fields");

  // ****************************************
  // bus checks
  // ****************************************
  // idle read data zero
  chk_rdata_idle_zero: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !I_RD |=> O_RDATA == 32'h0000_0000)
    else $error("read data not zero when idle");

  chk_unmapped_reads_zero: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_RD && !hit_header && !hit_limit) |=> O_RDATA == 32'h0000_0000)
    else $error("unmapped read not zero");

  chk_unmapped_write_ignored: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_WR && !hit_limit) |=> $stable(limit_word))
    else $error("unmapped write stored");

  chk_unmapped_fields_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_WR && !hit_limit) |=> $stable(O_SNOOP_VALUE) && $stable(O_SNOOP_SCALE) &&
    $stable(O_NOSNOOP_VALUE) && $stable(O_NOSNOOP_SCALE))
    else $error("unmapped write moved fields");

  chk_limit_hidden_downstream: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_RD && !I_UPSTREAM && (I_ADDR == ltr_cap_pkg::LIMIT_OFFSET)) |=> O_RDATA == 32'h0000_0000)
    else $error("latency word visible downstream");

  chk_limit_readback: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (limit_we ##1 (I_RD && hit_limit && !I_WR)) |=> O_RDATA == ($past(I_WDATA, 2) & 32'h1fff_1fff))
    else $error("latency word readback wrong");

  chk_rdata_reset_zero: assert property (@(posedge I_CLOCK)
    !I_RST_N |=> O_RDATA == 32'h0000_0000)
    else $error("read data not cleared by reset");

  // ****************************************
  // latency field checks
  // ****************************************
  // snoop value write
  chk_snoop_value_write: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    limit_we |=> O_SNOOP_VALUE == $past(I_WDATA[9:0]))
    else $error("snoop value not written");

  chk_snoop_value_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !limit_we |=> $stable(O_SNOOP_VALUE))
    else $error("snoop value changed without write");

  chk_snoop_scale_write: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    limit_we |=> O_SNOOP_SCALE == $past(I_WDATA[12:10]))
    else $error("snoop scale not written");

  chk_snoop_scale_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !limit_we |=> $stable(O_SNOOP_SCALE))
    else $error("snoop scale changed without write");

  chk_nosnoop_value_write: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    limit_we |=> O_NOSNOOP_VALUE == $past(I_WDATA[25:16]))
    else $error("no-snoop value not written");

  chk_nosnoop_value_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !limit_we |=> $stable(O_NOSNOOP_VALUE))
    else $error("no-snoop value changed without write");

  chk_nosnoop_scale_write: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    limit_we |=> O_NOSNOOP_SCALE == $past(I_WDATA[28:26]))
    else $error("no-snoop scale not written");

  chk_nosnoop_scale_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !limit_we |=> $stable(O_NOSNOOP_SCALE))
    else $error("no-snoop scale changed without write");

  chk_snoop_value_readback: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_RD && hit_limit) |=> O_RDATA[9:0] == O_SNOOP_VALUE)
    else $error("snoop value readback wrong");

  chk_snoop_scale_readback: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_RD && hit_limit) |=> O_RDATA[12:10] == O_SNOOP_SCALE)
    else $error("snoop scale readback wrong");

  chk_nosnoop_value_readback: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_RD && hit_limit) |=> O_RDATA[25:16] == O_NOSNOOP_VALUE)
    else $error("no-snoop value readback wrong");

  chk_nosnoop_scale_readback: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_RD && hit_limit) |=> O_RDATA[28:26] == O_NOSNOOP_SCALE)
    else $error("no-snoop scale readback wrong");

  chk_snoop_value_reset: assert property (@(posedge I_CLOCK)
    !I_RST_N |=> O_SNOOP_VALUE == 10'h000)
    else $error("snoop value not cleared by reset");

  chk_snoop_scale_reset: assert property (@(posedge I_CLOCK)
    !I_RST_N |=> O_SNOOP_SCALE == 3'h0)
    else $error("snoop scale not cleared by reset");

  chk_nosnoop_value_reset: assert property (@(posedge I_CLOCK)
    !I_RST_N |=> O_NOSNOOP_VALUE == 10'h000)
    else $error("no-snoop value not cleared by reset");

  chk_nosnoop_scale_reset: assert property (@(posedge I_CLOCK)
    !I_RST_N |=> O_NOSNOOP_SCALE == 3'h0)
    else $error("no-snoop scale not cleared by reset");

  chk_limit_word_write: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    limit_we |=> limit_word == ($past(I_WDATA) & 32'h1fff_1fff))
    else $error("latency word not stored masked");

  chk_reserved_zero: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_RD && hit_limit) |=> (O_RDATA[15:13] == 3'h0) && (O_RDATA[31:29] == 3'h0))
    else $error("reserved bits not zero");

  chk_reserved_never_stored: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (limit_word[15:13] == 3'h0) && (limit_word[31:29] == 3'h0))
    else $error("reserved bits stored");
endmodule

// [hw/ltr_limit_store.sv]
`timescale 1ns/10ps
module ltr_limit_store (
  input wire logic i_clock, // core clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_we, // write enable
  input wire logic [31:0] i_wdata, // write data
  output logic [31:0] o_word // stored word
);
  // ****************************************
  // masked latency word
  // ****************************************
  logic [31:0] word_q;
  logic [31:0] word_d;

  assign word_d = i_wdata & ltr_cap_pkg::LIMIT_WRITE_MASK;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word_q <= ltr_cap_pkg::LIMIT_RESET;
    end else if (i_we) begin
      word_q <= word_d;
    end
  end

  assign o_word = word_q;
endmodule

// [pkg/ltr_cap_pkg.sv]
package ltr_cap_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] HEADER_OFFSET = 12'h230;
  localparam logic [11:0] LIMIT_OFFSET = 12'h234;
  localparam logic [15:0] CAP_ID = 16'h0018;
  localparam logic [3:0] CAP_VERSION = 4'h1;
  localparam logic [11:0] NEXT_OFFSET = 12'h000;
  // ****************************************
  // latency word fields
  // ****************************************
  localparam int SNOOP_VAL_LSB = 0;
  localparam int SNOOP_SCALE_LSB = 10;
  localparam int NOSNOOP_VAL_LSB = 16;
  localparam int NOSNOOP_SCALE_LSB = 26;
  localparam int VAL_WIDTH = 10;
  localparam int SCALE_WIDTH = 3;
  localparam logic [31:0] LIMIT_WRITE_MASK = 32'h1fff_1fff;
  localparam logic [31:0] LIMIT_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
endpackage

// [verification/ltr_capability_registers_bench.sv]
`timescale 1ns/10ps
module ltr_capability_registers_bench;
  logic I_CLOCK = 1'b0;
  logic I_RST_N = 1'b0;
  logic I_UPSTREAM = 1'b1;
  logic [11:0] I_ADDR = 12'h000;
  logic [31:0] I_WDATA = 32'h0;
  logic I_WR = 1'b0;
  logic I_RD = 1'b0;
  logic [31:0] O_RDATA;
  logic [9:0] O_SNOOP_VALUE;
  logic [2:0] O_SNOOP_SCALE;
  logic [9:0] O_NOSNOOP_VALUE;
  logic [2:0] O_NOSNOOP_SCALE;
  logic [31:0] expq[$];
  logic [31:0] word;
  logic [31:0] hdr;
  logic rd_q = 1'b0;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  ltr_capability_registers dut (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_UPSTREAM(I_UPSTREAM), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_SNOOP_VALUE(O_SNOOP_VALUE),
    .O_SNOOP_SCALE(O_SNOOP_SCALE), .O_NOSNOOP_VALUE(O_NOSNOOP_VALUE), .O_NOSNOOP_SCALE(O_NOSNOOP_SCALE));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic summarize();
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask
  // one bus cycle per call, so each strobe is assigned once per time step
  task automatic acc(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
    I_WR <= w;
    I_RD <= r;
    I_ADDR <= a;
    I_WDATA <= d;
    if (r) expq.push_back(d);
    @(posedge I_CLOCK);
  endtask
  task automatic fields(input logic [31:0] e);
    cmp("fields", e, {3'h0, O_NOSNOOP_SCALE, O_NOSNOOP_VALUE, 3'h0, O_SNOOP_SCALE, O_SNOOP_VALUE});
  endtask
  // ****************************************
  // clock, monitor, timeout
  // ****************************************
  initial forever #20 I_CLOCK = ~I_CLOCK;
  always @(posedge I_CLOCK) begin
    if (rd_q) cmp("rdata", expq.pop_front(), O_RDATA);
    else if (I_RST_N) cmp("rdata_idle", 32'h0, O_RDATA);
    rd_q <= I_RD;
    cycles++;
    if (cycles == 3000) begin
      errors++;
      summarize();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    hdr = {ltr_cap_pkg::NEXT_OFFSET, ltr_cap_pkg::CAP_VERSION, ltr_cap_pkg::CAP_ID};
    void'($urandom(32'h88ee));
    repeat (16) @(posedge I_CLOCK);
    I_RST_N <= 1'b1;
    @(posedge I_CLOCK);
    acc(1'b0, 1'b1, 12'h230, hdr);
    acc(1'b0, 1'b1, 12'h234, 32'h0);
    fields(32'h0);
    acc(1'b1, 1'b0, 12'h230, $urandom());
    acc(1'b0, 1'b1, 12'h230, hdr);
    fields(32'h0);
    for (int i = 0; i < 10; i++) begin
      word = (i == 0) ? 32'hffff_ffff : $urandom();
      acc(1'b1, 1'b0, 12'h234, word);
      acc(1'b0, 1'b1, 12'h234, word & 32'h1fff_1fff);
      fields(word & 32'h1fff_1fff);
    end
    acc(1'b1, 1'b0, 12'h238, $urandom());
    acc(1'b0, 1'b1, 12'h238, 32'h0);
    acc(1'b0, 1'b1, 12'h234, word & 32'h1fff_1fff);
    I_UPSTREAM <= 1'b0;
    acc(1'b0, 1'b1, 12'h230, 32'h0);
    acc(1'b1, 1'b0, 12'h234, ~word);
    acc(1'b0, 1'b1, 12'h234, 32'h0);
    fields(word & 32'h1fff_1fff);
    I_UPSTREAM <= 1'b1;
    acc(1'b0, 1'b1, 12'h234, word & 32'h1fff_1fff);
    acc(1'b0, 1'b0, 12'h000, 32'h0);
    acc(1'b0, 1'b0, 12'h000, 32'h0);
    I_RST_N <= 1'b0;
    @(posedge I_CLOCK);
    fields(32'h0);
    I_RST_N <= 1'b1;
    @(posedge I_CLOCK);
    acc(1'b0, 1'b1, 12'h234, 32'h0);
    acc(1'b0, 1'b0, 12'h000, 32'h0);
    acc(1'b0, 1'b0, 12'h000, 32'h0);
    summarize();
  end
endmodule
